// File: rtl/probe_data_channel_pkg.sv
package probe_data_channel_pkg;

    // Register bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TAG_W = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_ACCESS = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RX = 8'h18;
    localparam logic [7:0] OFS_TX_BASE = 8'h20;
    localparam int TX_IDX_LSB = 3;
    localparam logic [4:0] TX_SLOTS = 5'h10;

    // Access control fields
    localparam int ACC_TYPE_LSB = 24;
    localparam int ACC_SIZE_LSB = 16;
    localparam int ACC_REV_LSB = 12;
    localparam int ACC_PERM_W = 4;
    localparam logic [5:0] ACC_SIZE_VAL = 6'h02;
    localparam logic [3:0] ACC_REV_VAL = 4'h0;
    localparam logic [3:0] ACC_PERM_RST = 4'h0;

    // Configuration fields
    localparam int CFG_TX_THR_LSB = 18;
    localparam int CFG_RX_THR_LSB = 16;
    localparam int CFG_TX_SIZE_LSB = 8;
    localparam int CFG_RX_SIZE_LSB = 0;

    // Status fields
    localparam int ST_TXF = 0;
    localparam int ST_TXE = 1;
    localparam int ST_RXF = 2;
    localparam int ST_RXE = 3;
    localparam int ST_RXCHAN_LSB = 4;

    // Probe-side shift register layout
    localparam int SHIFT_W = 38;
    localparam int SR_FLAG_BIT = 37;
    localparam int SR_VALID_BIT = 36;
    localparam int SR_TAG_LSB = 32;
    localparam logic [3:0] END_TAG = 4'hd;

    // Interrupt threshold encodings
    typedef enum logic [1:0] {
        THR_DISABLED = 2'h0,
        THR_EDGE = 2'h1,
        THR_NOT_EDGE = 2'h2,
        THR_ALMOST = 2'h3
    } thresh_e;

    // Test-port input synchroniser bit order
    localparam int TP_CLK = 0;
    localparam int TP_TDI = 1;
    localparam int TP_CAP = 2;
    localparam int TP_SHIFT = 3;
    localparam int TP_UPD = 4;
    localparam int TP_W = 5;

endpackage

// File: rtl/pin_sync2.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Asynchronous levels in, synchronised levels out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_reg;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// File: rtl/probe_data_channel.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module probe_data_channel #(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8,
    parameter logic [7:0] DEV_TYPE = 8'h5a // Arbitrary type code
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [probe_data_channel_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [probe_data_channel_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [probe_data_channel_pkg::DATA_W-1:0] reg_rdata_o,
    // Test port, channel instruction selected
    input wire logic test_port_clock_i,
    input wire logic test_port_tdi_i,
    input wire logic test_port_capture_i,
    input wire logic test_port_shift_i,
    input wire logic test_port_update_i,
    output logic test_port_tdo_o,
    // Interrupt
    input wire logic vectored_irq_controller_mode_i,
    input wire logic [2:0] channel_irq_pin_select_i,
    output logic channel_irq_pending_o,
    output logic channel_irq_out_o,
    output logic [2:0] irq_pin_select_field_o
);

    localparam int TXC_W = $clog2(TX_DEPTH + 1);
    localparam int RXC_W = $clog2(RX_DEPTH + 1);
    localparam int TXP_W = $clog2(TX_DEPTH);
    localparam int RXP_W = $clog2(RX_DEPTH);
    localparam int ENT_W = probe_data_channel_pkg::TAG_W + probe_data_channel_pkg::DATA_W;
    localparam logic [TXC_W-1:0] TX_FULL_CNT = TXC_W'(TX_DEPTH);
    localparam logic [RXC_W-1:0] RX_FULL_CNT = RXC_W'(RX_DEPTH);
    localparam logic [RXC_W-1:0] RX_ALMOST_CNT = RXC_W'(RX_DEPTH - 1);
    localparam logic [7:0] TX_SIZE_VAL = 8'(TX_DEPTH + 1);
    localparam logic [7:0] RX_SIZE_VAL = 8'(RX_DEPTH + 1);
    localparam int TX_IDX_LSB_M1 = probe_data_channel_pkg::TX_IDX_LSB - 1;

    // Synchronised test-port levels
    logic [probe_data_channel_pkg::TP_W-1:0] tp_raw;
    logic [probe_data_channel_pkg::TP_W-1:0] tp_sync;
    logic tck_prev_reg;
    logic tck_rise;
    logic tck_idle;

    // Shift register and per-shift bookkeeping
    logic [probe_data_channel_pkg::SHIFT_W-1:0] sr_reg;
    logic offered_reg;
    logic refused_reg;

    // Test-clock queue entries
    logic tx_tck_valid_reg;
    logic [ENT_W-1:0] tx_tck_reg;
    logic rx_tck_valid_reg;
    logic [ENT_W-1:0] rx_tck_reg;

    // Core-clock queues
    logic [ENT_W-1:0] tx_mem [TX_DEPTH];
    logic [TXP_W-1:0] tx_wp_reg;
    logic [TXP_W-1:0] tx_rp_reg;
    logic [TXC_W-1:0] tx_cnt_reg;
    logic [ENT_W-1:0] rx_mem [RX_DEPTH];
    logic [RXP_W-1:0] rx_wp_reg;
    logic [RXP_W-1:0] rx_rp_reg;
    logic [RXC_W-1:0] rx_cnt_reg;

    // Software registers
    logic [probe_data_channel_pkg::ACC_PERM_W-1:0] perm_reg;
    logic [1:0] tx_thr_reg;
    logic [1:0] rx_thr_reg;
    logic end_flag_reg;

    // Decode and status terms
    logic [7:0] tx_off;
    logic tx_hit;
    logic tx_push;
    logic tx_load;
    logic tx_done;
    logic rx_take;
    logic rx_move;
    logic rx_pop;
    logic end_event;
    logic tx_full;
    logic tx_empty;
    logic tx_core_empty;
    logic rx_full;
    logic rx_empty;
    logic rx_almost;
    logic tx_cond;
    logic rx_cond;
    logic irq_next;
    logic [probe_data_channel_pkg::DATA_W-1:0] rd_mux;

    // Test-port pins enter the core clock through two flip-flops
    assign tp_raw = {test_port_update_i, test_port_shift_i, test_port_capture_i,
                     test_port_tdi_i, test_port_clock_i};

    pin_sync2 #(
        .W(probe_data_channel_pkg::TP_W)
    ) u_tp_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(tp_raw),
        .q_o(tp_sync)
    );

    // Test clock edge found on the synchronised copy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tck_prev_reg <= 1'b0;
        end else begin
            tck_prev_reg <= tp_sync[probe_data_channel_pkg::TP_CLK];
        end
    end

    assign tck_rise = tp_sync[probe_data_channel_pkg::TP_CLK] & ~tck_prev_reg;
    assign tck_idle = ~(tp_sync[probe_data_channel_pkg::TP_CAP] | tp_sync[probe_data_channel_pkg::TP_SHIFT] |
                        tp_sync[probe_data_channel_pkg::TP_UPD]);

    // Probe-facing events, all but rx_move on test clock edges
    assign tx_done = tck_rise & tp_sync[probe_data_channel_pkg::TP_UPD] & offered_reg &
                     sr_reg[probe_data_channel_pkg::SR_FLAG_BIT];
    assign rx_take = tck_rise & tp_sync[probe_data_channel_pkg::TP_UPD] & ~refused_reg &
                     sr_reg[probe_data_channel_pkg::SR_VALID_BIT];
    assign end_event = tck_rise & tp_sync[probe_data_channel_pkg::TP_UPD] &
                       ~sr_reg[probe_data_channel_pkg::SR_VALID_BIT] &
                       (sr_reg[probe_data_channel_pkg::SR_TAG_LSB +: probe_data_channel_pkg::TAG_W] ==
                        probe_data_channel_pkg::END_TAG);
    assign tx_load = tck_rise & tck_idle & ~tx_tck_valid_reg & (tx_cnt_reg != '0);
    assign rx_move = rx_tck_valid_reg & (rx_cnt_reg != RX_FULL_CNT);

    // Shift register: capture, shift, and remember what was offered
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_reg <= '0;
            offered_reg <= 1'b0;
            refused_reg <= 1'b1;
        end else if (tck_rise && tp_sync[probe_data_channel_pkg::TP_CAP]) begin
            sr_reg <= {rx_tck_valid_reg, tx_tck_valid_reg, tx_tck_reg};
            offered_reg <= tx_tck_valid_reg;
            refused_reg <= rx_tck_valid_reg;
        end else if (tck_rise && tp_sync[probe_data_channel_pkg::TP_SHIFT]) begin
            sr_reg <= {tp_sync[probe_data_channel_pkg::TP_TDI],
                       sr_reg[probe_data_channel_pkg::SHIFT_W-1:1]};
        end else if (tck_rise && tp_sync[probe_data_channel_pkg::TP_UPD]) begin
            offered_reg <= 1'b0;
            refused_reg <= 1'b1;
        end
    end

    // Serial output from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            test_port_tdo_o <= 1'b0;
        end else begin
            test_port_tdo_o <= sr_reg[0];
        end
    end

    // Outbound test-clock entry: loaded from core queue, freed by probe accept
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_tck_valid_reg <= 1'b0;
            tx_tck_reg <= '0;
        end else if (tx_done) begin
            tx_tck_valid_reg <= 1'b0;
        end else if (tx_load) begin
            tx_tck_valid_reg <= 1'b1;
            tx_tck_reg <= tx_mem[tx_rp_reg];
        end
    end

    // Inbound test-clock entry: filled by probe, drained into core queue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_tck_valid_reg <= 1'b0;
            rx_tck_reg <= '0;
        end else if (rx_take) begin
            rx_tck_valid_reg <= 1'b1;
            rx_tck_reg <= sr_reg[ENT_W-1:0];
        end else if (rx_move) begin
            rx_tck_valid_reg <= 1'b0;
        end
    end

    // Outbound register address decode, one slot per channel tag
    assign tx_off = reg_addr_i - probe_data_channel_pkg::OFS_TX_BASE;
    assign tx_hit = reg_write_i && (reg_addr_i >= probe_data_channel_pkg::OFS_TX_BASE) &&
                    (tx_off[TX_IDX_LSB_M1:0] == '0) &&
                    (tx_off[7:probe_data_channel_pkg::TX_IDX_LSB] < probe_data_channel_pkg::TX_SLOTS);
    assign tx_push = tx_hit & ~tx_full;
    assign rx_pop = reg_read_i && (reg_addr_i == probe_data_channel_pkg::OFS_RX) && ~rx_empty;

    // Outbound core queue, drained into the test-clock entry only on idle test clock edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_wp_reg <= '0;
            tx_rp_reg <= '0;
            tx_cnt_reg <= '0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_reg] <= {tx_off[probe_data_channel_pkg::TX_IDX_LSB +: probe_data_channel_pkg::TAG_W],
                                      reg_wdata_i};
                tx_wp_reg <= (tx_wp_reg == TXP_W'(TX_DEPTH - 1)) ? '0 : tx_wp_reg + 1'b1;
            end
            if (tx_load) begin
                tx_rp_reg <= (tx_rp_reg == TXP_W'(TX_DEPTH - 1)) ? '0 : tx_rp_reg + 1'b1;
            end
            tx_cnt_reg <= tx_cnt_reg + TXC_W'(tx_push) - TXC_W'(tx_load);
        end
    end

    // Inbound core queue
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_wp_reg <= '0;
            rx_rp_reg <= '0;
            rx_cnt_reg <= '0;
        end else begin
            if (rx_move) begin
                rx_mem[rx_wp_reg] <= rx_tck_reg;
                rx_wp_reg <= (rx_wp_reg == RXP_W'(RX_DEPTH - 1)) ? '0 : rx_wp_reg + 1'b1;
            end
            if (rx_pop) begin
                rx_rp_reg <= (rx_rp_reg == RXP_W'(RX_DEPTH - 1)) ? '0 : rx_rp_reg + 1'b1;
            end
            rx_cnt_reg <= rx_cnt_reg + RXC_W'(rx_move) - RXC_W'(rx_pop);
        end
    end

    // Queue status as software sees it
    assign tx_full = (tx_cnt_reg == TX_FULL_CNT);
    assign tx_core_empty = (tx_cnt_reg == '0);
    assign tx_empty = tx_core_empty & ~tx_tck_valid_reg;
    assign rx_full = (rx_cnt_reg == RX_FULL_CNT);
    assign rx_empty = (rx_cnt_reg == '0);
    assign rx_almost = (rx_cnt_reg >= RX_ALMOST_CNT);

    // Software-written control fields
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            perm_reg <= probe_data_channel_pkg::ACC_PERM_RST;
            tx_thr_reg <= probe_data_channel_pkg::THR_DISABLED;
            rx_thr_reg <= probe_data_channel_pkg::THR_DISABLED;
        end else if (reg_write_i) begin
            if (reg_addr_i == probe_data_channel_pkg::OFS_ACCESS) begin
                perm_reg <= reg_wdata_i[probe_data_channel_pkg::ACC_PERM_W-1:0];
            end
            if (reg_addr_i == probe_data_channel_pkg::OFS_CONFIG) begin
                tx_thr_reg <= reg_wdata_i[probe_data_channel_pkg::CFG_TX_THR_LSB +: 2];
                rx_thr_reg <= reg_wdata_i[probe_data_channel_pkg::CFG_RX_THR_LSB +: 2];
            end
        end
    end

    // Read data mux, unmapped addresses read zero
    always_comb begin
        rd_mux = '0;
        case (reg_addr_i)
            probe_data_channel_pkg::OFS_ACCESS: begin
                rd_mux[probe_data_channel_pkg::ACC_TYPE_LSB +: 8] = DEV_TYPE;
                rd_mux[probe_data_channel_pkg::ACC_SIZE_LSB +: 6] = probe_data_channel_pkg::ACC_SIZE_VAL;
                rd_mux[probe_data_channel_pkg::ACC_REV_LSB +: 4] = probe_data_channel_pkg::ACC_REV_VAL;
                rd_mux[probe_data_channel_pkg::ACC_PERM_W-1:0] = perm_reg;
            end
            probe_data_channel_pkg::OFS_CONFIG: begin
                rd_mux[probe_data_channel_pkg::CFG_TX_THR_LSB +: 2] = tx_thr_reg;
                rd_mux[probe_data_channel_pkg::CFG_RX_THR_LSB +: 2] = rx_thr_reg;
                rd_mux[probe_data_channel_pkg::CFG_TX_SIZE_LSB +: 8] = TX_SIZE_VAL;
                rd_mux[probe_data_channel_pkg::CFG_RX_SIZE_LSB +: 8] = RX_SIZE_VAL;
            end
            probe_data_channel_pkg::OFS_STATUS: begin
                rd_mux[probe_data_channel_pkg::ST_TXF] = tx_full;
                rd_mux[probe_data_channel_pkg::ST_TXE] = tx_empty;
                rd_mux[probe_data_channel_pkg::ST_RXF] = rx_full;
                rd_mux[probe_data_channel_pkg::ST_RXE] = rx_empty;
                rd_mux[probe_data_channel_pkg::ST_RXCHAN_LSB +: probe_data_channel_pkg::TAG_W] =
                    rx_mem[rx_rp_reg][ENT_W-1:probe_data_channel_pkg::DATA_W];
            end
            probe_data_channel_pkg::OFS_RX: begin
                rd_mux = rx_empty ? '0 : rx_mem[rx_rp_reg][probe_data_channel_pkg::DATA_W-1:0];
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else begin
            reg_rdata_o <= reg_read_i ? rd_mux : '0;
        end
    end

    // Probe end-of-sending marker, set wins over the clearing read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            end_flag_reg <= 1'b0;
        end else if (end_event) begin
            end_flag_reg <= 1'b1;
        end else if (reg_read_i && (reg_addr_i == probe_data_channel_pkg::OFS_RX)) begin
            end_flag_reg <= 1'b0;
        end
    end

    // Transmit threshold condition
    always_comb begin
        case (tx_thr_reg)
            probe_data_channel_pkg::THR_DISABLED: tx_cond = 1'b0;
            probe_data_channel_pkg::THR_EDGE: tx_cond = tx_empty;
            probe_data_channel_pkg::THR_NOT_EDGE: tx_cond = ~tx_full;
            probe_data_channel_pkg::THR_ALMOST: tx_cond = tx_core_empty;
            default: tx_cond = 1'b0;
        endcase
    end

    // Receive threshold condition
    always_comb begin
        case (rx_thr_reg)
            probe_data_channel_pkg::THR_DISABLED: rx_cond = 1'b0;
            probe_data_channel_pkg::THR_EDGE: rx_cond = rx_full | end_flag_reg;
            probe_data_channel_pkg::THR_NOT_EDGE: rx_cond = ~rx_empty | end_flag_reg;
            probe_data_channel_pkg::THR_ALMOST: rx_cond = rx_almost | end_flag_reg;
            default: rx_cond = 1'b0;
        endcase
    end

    assign irq_next = tx_cond | rx_cond;

    // Ordinary interrupt level towards the core and its cause state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            channel_irq_pending_o <= 1'b0;
            channel_irq_out_o <= 1'b0;
            irq_pin_select_field_o <= 3'h0;
        end else begin
            channel_irq_pending_o <= irq_next;
            channel_irq_out_o <= irq_next;
            irq_pin_select_field_o <= vectored_irq_controller_mode_i ? 3'h0 : channel_irq_pin_select_i;
        end
    end

endmodule

`default_nettype wire

// File: verification/probe_data_channel_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Port checks on the register port and the interrupt outputs
module probe_data_channel_monitor #(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8,
    parameter logic [7:0] DEV_TYPE = 8'h5a // Arbitrary type code
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    // Interrupt
    input wire logic vectored_irq_controller_mode_i,
    input wire logic [2:0] channel_irq_pin_select_i,
    input wire logic channel_irq_pending_o,
    input wire logic channel_irq_out_o,
    input wire logic [2:0] irq_pin_select_field_o
);
    logic [3:0] thr_reg;

    // Shadow of both threshold fields as software wrote them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            thr_reg <= 4'h0;
        end else if (reg_write_i && reg_addr_i == probe_data_channel_pkg::OFS_CONFIG) begin
            thr_reg <= reg_wdata_i[19:16];
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Register answers
    property p_rdata_idle;
        !$past(reg_read_i) |-> reg_rdata_o == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer cycle");
    property p_type;
        reg_read_i && reg_addr_i == 8'h00 |=> reg_rdata_o[31:12] == {DEV_TYPE, 2'h0, 6'h02, 4'h0};
    endproperty
    a_type: assert property (p_type) else $error("type code field wrong");
    property p_cfg;
        reg_read_i && reg_addr_i == 8'h08 |=>
            reg_rdata_o == {12'h0, thr_reg, 8'(TX_DEPTH + 1), 8'(RX_DEPTH + 1)};
    endproperty
    a_cfg: assert property (p_cfg) else $error("config read wrong");
    property p_status;
        reg_read_i && reg_addr_i == 8'h10 |=>
            reg_rdata_o[31:8] == 24'h0 && !(reg_rdata_o[3] && reg_rdata_o[2]) && !(reg_rdata_o[1] && reg_rdata_o[0]);
    endproperty
    a_status: assert property (p_status) else $error("status flags inconsistent");
    property p_unmapped;
        reg_read_i && (reg_addr_i[2:0] != 3'h0 || reg_addr_i >= 8'ha0) |=> reg_rdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // Interrupt outputs
    property p_irq_same;
        channel_irq_out_o == channel_irq_pending_o;
    endproperty
    a_irq_same: assert property (p_irq_same) else $error("pending and output differ");
    property p_field;
        !$past(rst_i) |-> irq_pin_select_field_o ==
            ($past(vectored_irq_controller_mode_i) ? 3'h0 : $past(channel_irq_pin_select_i));
    endproperty
    a_field: assert property (p_field) else $error("pin select field wrong");
    property p_irq_off;
        thr_reg == 4'h0 && $past(thr_reg) == 4'h0 && $past(thr_reg, 2) == 4'h0 |-> !channel_irq_pending_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt while disabled");

    // Main scenarios reached
    c_irq_rise: cover property ($rose(channel_irq_pending_o));
    c_status: cover property (reg_read_i && reg_addr_i == 8'h10);
    c_field: cover property (irq_pin_select_field_o != 3'h0);
endmodule

bind probe_data_channel probe_data_channel_monitor #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH), .DEV_TYPE(DEV_TYPE)
) mon_u (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
    .vectored_irq_controller_mode_i, .channel_irq_pin_select_i, .channel_irq_pending_o, .channel_irq_out_o,
    .irq_pin_select_field_o);

`default_nettype wire

// File: verification/probe_model.sv
`timescale 1ns/1ps
`default_nettype none

// Debug probe on the test port; its clock stands still between frames
module probe_model (
    // Test port towards the channel
    output logic tck_o,
    output logic tdi_o,
    output logic cap_o,
    output logic shift_o,
    output logic upd_o,
    input wire logic tdo_i
);
    // Idle levels
    initial begin
        tck_o = 1'b0;
        tdi_o = 1'b0;
        cap_o = 1'b0;
        shift_o = 1'b0;
        upd_o = 1'b0;
    end

    // One test clock period of 64 ns
    task automatic pulse();
        #32 tck_o = 1'b1;
        #32 tck_o = 1'b0;
    endtask

    // Frame: capture, 38 shifts LSB first, update, one idle edge to refill
    task automatic scan(input logic [37:0] din, output logic [37:0] dout);
        cap_o = 1'b1;
        pulse();
        cap_o = 1'b0;
        shift_o = 1'b1;
        for (int k = 0; k < 38; k++) begin
            dout[k] = tdo_i; // Sampled on the falling edge
            tdi_o = din[k];
            pulse();
        end
        shift_o = 1'b0;
        upd_o = 1'b1;
        pulse();
        upd_o = 1'b0;
        tdi_o = ~tdi_o; // Released line does not keep the last bit
        pulse();
    endtask
endmodule

`default_nettype wire

// File: verification/test_probe_data_channel.sv
`timescale 1ns/1ps
`default_nettype none

// Register and test port scenarios for the probe data channel
module test_probe_data_channel;
    localparam int TXD = 4;
    localparam int RXD = 4;
    localparam logic [7:0] DEV_TYPE = 8'h3c; // Arbitrary type code
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic tck, tdi, cap, sft, upd, tdo;
    logic vmode = 1'b0;
    logic [2:0] pin_sel = 3'h5;
    logic pend, irq_o;
    logic [2:0] field;
    logic [31:0] d;
    logic [37:0] so;
    int mismatches = 0;
    int num_checks = 0;
    int n;
    int m;

    // Core clock 200 MHz
    always #2.5 clk_i = ~clk_i;

    probe_data_channel #(.TX_DEPTH(TXD), .RX_DEPTH(RXD), .DEV_TYPE(DEV_TYPE)) dut_u (
        .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i, .reg_rdata_o,
        .test_port_clock_i(tck), .test_port_tdi_i(tdi), .test_port_capture_i(cap),
        .test_port_shift_i(sft), .test_port_update_i(upd), .test_port_tdo_o(tdo),
        .vectored_irq_controller_mode_i(vmode), .channel_irq_pin_select_i(pin_sel),
        .channel_irq_pending_o(pend), .channel_irq_out_o(irq_o), .irq_pin_select_field_o(field));

    probe_model probe_u (.tck_o(tck), .tdi_o(tdi), .cap_o(cap), .shift_o(sft), .upd_o(upd), .tdo_i(tdo));

    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Loop bound used up ends the run
    task automatic bound(input logic ok);
        if (!ok) begin
            mismatches++;
            finish_test();
        end
    endtask

    // Register write and read cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_write_i <= 1'b1;
        @(posedge clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clk_i);
        reg_read_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Threshold setup and interrupt level check
    task automatic cfg(input logic [1:0] tx, input logic [1:0] rx);
        wr(probe_data_channel_pkg::OFS_CONFIG, {12'h0, tx, rx, 16'h0});
    endtask
    task automatic irq(input logic e);
        repeat (4) @(posedge clk_i);
        #1 chk({pend, irq_o}, {e, e});
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(8'h00);
        chk(d, {DEV_TYPE, 2'h0, 6'h02, 4'h0, 12'h0});
        wr(8'h00, 32'hffffffff);
        rd(8'h00);
        chk(d, {DEV_TYPE, 2'h0, 6'h02, 4'h0, 12'h00f});
        rd(probe_data_channel_pkg::OFS_STATUS);
        chk(d[3:0], 4'ha);
        rd(8'h04);
        chk(d, 32'h0);
        #1 chk(field, 3'h5);
        @(posedge clk_i);
        vmode <= 1'b1;
        irq(1'b0);
        chk(field, 3'h0);
        for (n = 0; n < 4; n++) begin
            cfg(n[1:0], 2'h0);
            irq(n != 0);
            cfg(2'h0, n[1:0]);
            irq(1'b0);
            rd(probe_data_channel_pkg::OFS_CONFIG);
            chk(d[19:16], {2'h0, n[1:0]});
        end
        // Fill outbound core entries, one extra write is dropped
        cfg(2'h1, 2'h0);
        for (n = 0; n <= TXD; n++) begin
            wr(probe_data_channel_pkg::OFS_TX_BASE + 8'(8 * n), 32'ha5000000 + n);
        end
        rd(probe_data_channel_pkg::OFS_STATUS);
        chk(d[3:0], 4'h9);
        irq(1'b0);
        cfg(2'h2, 2'h0);
        irq(1'b0);
        cfg(2'h3, 2'h0);
        irq(1'b0);
        // Probe drains outbound while sending three inbound words
        n = 0;
        for (m = 0; m < 12 && (n == 0 || so[36]); m++) begin
            probe_u.scan({1'b1, m < 3, 4'h3, 32'hc0de0000 + m}, so);
            if (so[36]) begin
                chk(so[31:0], 32'ha5000000 + n);
                chk(so[35:32], n[3:0]);
                n++;
            end
        end
        bound(n == TXD);
        irq(1'b1);
        cfg(2'h1, 2'h0);
        irq(1'b1);
        rd(probe_data_channel_pkg::OFS_STATUS);
        chk(d[7:0], 8'h32);
        cfg(2'h0, 2'h2);
        irq(1'b1);
        cfg(2'h0, 2'h3);
        irq(1'b1);
        for (n = 0; n < 4; n++) begin
            rd(probe_data_channel_pkg::OFS_RX);
            chk(d, n < 3 ? 32'hc0de0000 + n : 32'h0);
        end
        irq(1'b0);
        // Inbound filled until the probe is refused
        cfg(2'h0, 2'h1);
        for (n = 0; n < 12; n++) begin
            probe_u.scan({1'b1, 1'b1, 4'h6, n}, so);
            if (so[37]) break;
        end
        bound(n >= RXD && n < 12);
        irq(1'b1);
        rd(probe_data_channel_pkg::OFS_STATUS);
        chk(d[7:2], 6'h19);
        for (m = 0; m < n; m++) begin
            rd(probe_data_channel_pkg::OFS_RX);
            chk(d, m);
        end
        rd(probe_data_channel_pkg::OFS_STATUS);
        chk(d[3:2], 2'h2);
        // End marker from the probe
        cfg(2'h0, 2'h2);
        irq(1'b0);
        probe_u.scan({1'b1, 1'b0, 4'hd, 32'h0}, so);
        irq(1'b1);
        rd(probe_data_channel_pkg::OFS_RX);
        irq(1'b0);
        finish_test();
    end
endmodule

`default_nettype wire
